//--- rtl/hpmbx_top.sv
// Host port mailbox, message flags and host-side status word.
// Function
// - Host mailbox write raises CPU receive-full interrupt.
// - Host mailbox read raises CPU transmit-empty interrupt.
// - CPU mailbox write asserts host interrupt line.
// - Mailbox holds and returns full 16 bits.
// - Status word is host-only and read-only.
// - Status reads start no CPU memory cycle.
// - Bit 15 shows bus power above threshold.
// - Bit 14 shows the OTG identity pin.
// - Bits 12, 10 flag frame-marker events.
// - Bits 9, 1 flag bus reset events.
// - Bit 8 set while incoming message waits.
// - Bits 7, 6 flag wakeup events.
// - Bits 5, 4 flag engine message writes.
// - Bits 3, 2 flag packet or endpoint completion.
// - Bit 0 set while outgoing message waits.
// - Any message register write sets flag, host interrupt.
// - Routed engine events go to host, not CPU.
// - Mailbox at CPU address 0xc0c6, resets zero.
`timescale 1ns/1ps
`default_nettype none
module hpmbx_top #(
  parameter int unsigned DW = hpmbx_pkg::DATA_W
) (
  input  wire logic                   core_clk,               // System clock, 25 MHz.
  input  wire logic                   sys_rst,                // Synchronous reset, active high.
  input  wire logic [15:0]            cpu_addr,               // CPU word address.
  input  wire logic                   cpu_wr,                 // CPU write strobe.
  input  wire logic                   cpu_rd,                 // CPU read strobe.
  input  wire logic [DW-1:0]          cpu_wdata,              // CPU write data.
  output logic      [DW-1:0]          cpu_rdata,              // CPU read data, mailbox or zero.
  input  wire logic                   rx_full_irq_en,         // Enable of the receive-full interrupt.
  input  wire logic                   tx_empty_irq_en,        // Enable of the transmit-empty interrupt.
  output logic                        cpu_receive_full_irq,   // CPU receive-full interrupt.
  output logic                        cpu_transmit_empty_irq, // CPU transmit-empty interrupt.
  input  wire logic                   host_mbx_wr,            // Host port mailbox write strobe.
  input  wire logic                   host_mbx_rd,            // Host port mailbox read strobe.
  input  wire logic                   host_status_rd,         // Host port status word read strobe.
  input  wire logic [DW-1:0]          host_wdata,             // Host port write data.
  output logic      [DW-1:0]          host_mbx_rdata,         // Mailbox word seen by the host.
  output logic      [DW-1:0]          host_status_word,       // Status word seen by the host.
  output logic                        host_mem_cycle,         // Pulse: host access used a CPU cycle.
  output logic                        host_irq_out,           // Host interrupt line, active high.
  input  wire logic [15:0]            route_sel,              // Interrupt routing word.
  input  wire logic [hpmbx_pkg::EV_N-1:0] engine_irq,         // Engine interrupt levels.
  input  wire logic                   bus_power_above,        // Bus power comparator output.
  input  wire logic                   otg_id_pin,             // OTG identity pin level.
  output logic [hpmbx_pkg::EV_N-1:0]  cpu_engine_irq          // Engine interrupts left to the CPU.
);
  // Address decode shared by the write and read paths.
  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] b);
    addr_hit = (a == b);
  endfunction

  wire cpu_mbx_wr  = cpu_wr & addr_hit(cpu_addr, hpmbx_pkg::MBX_ADDR);
  wire cpu_mbx_rd  = cpu_rd & addr_hit(cpu_addr, hpmbx_pkg::MBX_ADDR);
  wire eng1_msg_wr = cpu_wr & addr_hit(cpu_addr, hpmbx_pkg::ENG1_MSG_ADDR);
  wire eng2_msg_wr = cpu_wr & addr_hit(cpu_addr, hpmbx_pkg::ENG2_MSG_ADDR);

  logic [DW-1:0] mbx_reg;
  logic [DW-1:0] mbx_next;
  logic [DW-1:0] cpu_rdata_reg;
  logic [DW-1:0] status_reg;
  logic [DW-1:0] status_next;
  logic          host_irq_reg;
  logic          host_irq_next;
  logic          rx_irq_reg;
  logic          tx_irq_reg;
  logic          mem_cycle_reg;
  logic [hpmbx_pkg::EV_N-1:0] cpu_ev_reg;
  logic [hpmbx_pkg::EV_N-1:0] routed;
  logic [hpmbx_pkg::FL_N-1:0] fl_set;
  logic [hpmbx_pkg::FL_N-1:0] fl_clr;
  logic [hpmbx_pkg::FL_N-1:0] flags;

  // Mailbox data: a CPU write overrides a host write in the same cycle.
  assign mbx_next = cpu_mbx_wr  ? cpu_wdata :
                    host_mbx_wr ? host_wdata : mbx_reg;

  // Flag set and clear sources; the flag cells let a set beat a clear.
  assign fl_set[hpmbx_pkg::FL_MBX_IN]   = host_mbx_wr;
  assign fl_clr[hpmbx_pkg::FL_MBX_IN]   = cpu_mbx_rd;
  assign fl_set[hpmbx_pkg::FL_MBX_OUT]  = cpu_mbx_wr;
  assign fl_clr[hpmbx_pkg::FL_MBX_OUT]  = host_mbx_rd;
  assign fl_set[hpmbx_pkg::FL_RX_FULL]  = host_mbx_wr;
  assign fl_clr[hpmbx_pkg::FL_RX_FULL]  = cpu_mbx_rd;
  assign fl_set[hpmbx_pkg::FL_TX_EMPTY] = host_mbx_rd;
  assign fl_clr[hpmbx_pkg::FL_TX_EMPTY] = cpu_mbx_wr;
  assign fl_set[hpmbx_pkg::FL_ENG2_MSG] = eng2_msg_wr;
  assign fl_clr[hpmbx_pkg::FL_ENG2_MSG] = host_status_rd;
  assign fl_set[hpmbx_pkg::FL_ENG1_MSG] = eng1_msg_wr;
  assign fl_clr[hpmbx_pkg::FL_ENG1_MSG] = host_status_rd;

  hpmbx_flags #(
    .WIDTH (hpmbx_pkg::FL_N)
  ) u_flags (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .set_i    (fl_set),
    .clr_i    (fl_clr),
    .flag_o   (flags)
  );

  // Engine events split by the routing word between host port and CPU.
  assign routed[hpmbx_pkg::EV_BUS_POWER] = route_sel[hpmbx_pkg::RT_BUS_POWER];
  assign routed[hpmbx_pkg::EV_OTG_ID]    = route_sel[hpmbx_pkg::RT_OTG_ID];
  assign routed[hpmbx_pkg::EV_FRAME2]    = route_sel[hpmbx_pkg::RT_FRAME2];
  assign routed[hpmbx_pkg::EV_FRAME1]    = route_sel[hpmbx_pkg::RT_FRAME1];
  assign routed[hpmbx_pkg::EV_BUSRESET2] = route_sel[hpmbx_pkg::RT_BUSRESET2];
  assign routed[hpmbx_pkg::EV_WAKEUP2]   = route_sel[hpmbx_pkg::RT_WAKEUP2];
  assign routed[hpmbx_pkg::EV_WAKEUP1]   = route_sel[hpmbx_pkg::RT_WAKEUP1];
  assign routed[hpmbx_pkg::EV_COMPLETE2] = route_sel[hpmbx_pkg::RT_COMPLETE2];
  assign routed[hpmbx_pkg::EV_COMPLETE1] = route_sel[hpmbx_pkg::RT_COMPLETE1];
  assign routed[hpmbx_pkg::EV_BUSRESET1] = route_sel[hpmbx_pkg::RT_BUSRESET1];

  wire [hpmbx_pkg::EV_N-1:0] ev_host = engine_irq & routed;
  wire [hpmbx_pkg::EV_N-1:0] ev_cpu  = engine_irq & ~routed;

  // Status word assembly; reserved bits 13 and 11 read zero.
  always_comb
  begin
    status_next = '0;
    status_next[hpmbx_pkg::ST_BUS_POWER] = bus_power_above;
    status_next[hpmbx_pkg::ST_OTG_ID]    = otg_id_pin;
    status_next[hpmbx_pkg::ST_FRAME2]    = ev_host[hpmbx_pkg::EV_FRAME2];
    status_next[hpmbx_pkg::ST_FRAME1]    = ev_host[hpmbx_pkg::EV_FRAME1];
    status_next[hpmbx_pkg::ST_BUSRESET2] = ev_host[hpmbx_pkg::EV_BUSRESET2];
    status_next[hpmbx_pkg::ST_BUSRESET1] = ev_host[hpmbx_pkg::EV_BUSRESET1];
    status_next[hpmbx_pkg::ST_MBX_IN]    = flags[hpmbx_pkg::FL_MBX_IN];
    status_next[hpmbx_pkg::ST_WAKEUP2]   = ev_host[hpmbx_pkg::EV_WAKEUP2];
    status_next[hpmbx_pkg::ST_WAKEUP1]   = ev_host[hpmbx_pkg::EV_WAKEUP1];
    status_next[hpmbx_pkg::ST_ENG2_MSG]  = flags[hpmbx_pkg::FL_ENG2_MSG];
    status_next[hpmbx_pkg::ST_ENG1_MSG]  = flags[hpmbx_pkg::FL_ENG1_MSG];
    status_next[hpmbx_pkg::ST_COMPLETE2] = ev_host[hpmbx_pkg::EV_COMPLETE2];
    status_next[hpmbx_pkg::ST_COMPLETE1] = ev_host[hpmbx_pkg::EV_COMPLETE1];
    status_next[hpmbx_pkg::ST_MBX_OUT]   = flags[hpmbx_pkg::FL_MBX_OUT];
  end

  // Host interrupt: outgoing mail, message flags and any routed engine event.
  assign host_irq_next = flags[hpmbx_pkg::FL_MBX_OUT] | flags[hpmbx_pkg::FL_ENG2_MSG]
                       | flags[hpmbx_pkg::FL_ENG1_MSG] | (|ev_host);

  // Mailbox register and the CPU read port, which never sees the status word.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      mbx_reg       <= hpmbx_pkg::MBX_RESET;
      cpu_rdata_reg <= '0;
    end
    else
    begin
      mbx_reg       <= mbx_next;
      cpu_rdata_reg <= cpu_mbx_rd ? mbx_reg : '0;
    end
  end

  // Output flip-flops for status, interrupts and the host cycle pulse.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      status_reg    <= '0;
      host_irq_reg  <= 1'b0;
      rx_irq_reg    <= 1'b0;
      tx_irq_reg    <= 1'b0;
      mem_cycle_reg <= 1'b0;
      cpu_ev_reg    <= '0;
    end
    else
    begin
      status_reg    <= status_next;
      host_irq_reg  <= host_irq_next;
      rx_irq_reg    <= flags[hpmbx_pkg::FL_RX_FULL] & rx_full_irq_en;
      tx_irq_reg    <= flags[hpmbx_pkg::FL_TX_EMPTY] & tx_empty_irq_en;
      mem_cycle_reg <= host_mbx_wr | host_mbx_rd;
      cpu_ev_reg    <= ev_cpu;
    end
  end

  assign cpu_rdata              = cpu_rdata_reg;
  assign host_mbx_rdata         = mbx_reg;
  assign host_status_word       = status_reg;
  assign host_irq_out           = host_irq_reg;
  assign cpu_receive_full_irq   = rx_irq_reg;
  assign cpu_transmit_empty_irq = tx_irq_reg;
  assign host_mem_cycle         = mem_cycle_reg;
  assign cpu_engine_irq         = cpu_ev_reg;

  // Checks on the mailbox handshakes and the status word.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Interrupts toward the CPU follow their flags two edges after the strobe.
  a_rx_full_set: assert property (
    host_mbx_wr && rx_full_irq_en ##1 rx_full_irq_en |=> cpu_receive_full_irq)
    else $error("receive-full not raised");
  a_rx_full_clr: assert property (
    cpu_mbx_rd && !host_mbx_wr ##1 !host_mbx_wr |=> !cpu_receive_full_irq)
    else $error("receive-full not cleared");
  a_tx_empty_set: assert property (
    host_mbx_rd && tx_empty_irq_en ##1 tx_empty_irq_en |=> cpu_transmit_empty_irq)
    else $error("transmit-empty not raised");
  a_tx_empty_clr: assert property (
    cpu_mbx_wr && !host_mbx_rd ##1 !host_mbx_rd |=> !cpu_transmit_empty_irq)
    else $error("transmit-empty not cleared");

  // The host line rises on outgoing mail and falls once the host has taken it.
  a_host_irq_set: assert property (
    cpu_mbx_wr |-> ##2 host_irq_out)
    else $error("host interrupt missing after CPU write");
  a_host_irq_clr: assert property (
    host_mbx_rd && !cpu_mbx_wr && !eng1_msg_wr && !eng2_msg_wr
    && !flags[hpmbx_pkg::FL_ENG1_MSG] && !flags[hpmbx_pkg::FL_ENG2_MSG]
    ##1 ev_host == '0 |=> !host_irq_out)
    else $error("host interrupt not released");
  a_host_irq_event: assert property (
    (|ev_host) |=> host_irq_out)
    else $error("routed event missed the host interrupt");

  // Mailbox contents, the CPU read port and the host cycle pulse.
  a_mbx_hold_word: assert property (
    host_mbx_wr && !cpu_mbx_wr |=> host_mbx_rdata == $past(host_wdata))
    else $error("mailbox lost data");
  a_mbx_idle: assert property (
    !cpu_mbx_wr && !host_mbx_wr |=> $stable(host_mbx_rdata))
    else $error("mailbox changed with no write");
  a_cpu_rd_idle: assert property (
    !cpu_mbx_rd |=> cpu_rdata == '0)
    else $error("CPU read data without a mailbox read");
  a_status_cycle: assert property (
    host_status_rd && !host_mbx_wr && !host_mbx_rd |=> !host_mem_cycle)
    else $error("status read used a CPU cycle");

  // Level bits of the status word trail their inputs by one edge.
  a_bus_power_bit: assert property (
    ##1 host_status_word[hpmbx_pkg::ST_BUS_POWER] == $past(bus_power_above))
    else $error("bus power bit wrong");
  a_otg_id_bit: assert property (
    ##1 host_status_word[hpmbx_pkg::ST_OTG_ID] == $past(otg_id_pin))
    else $error("identity pin bit wrong");
  a_frame_bits: assert property (
    ##1 {host_status_word[hpmbx_pkg::ST_FRAME2], host_status_word[hpmbx_pkg::ST_FRAME1]}
    == $past({engine_irq[hpmbx_pkg::EV_FRAME2] & route_sel[hpmbx_pkg::RT_FRAME2],
              engine_irq[hpmbx_pkg::EV_FRAME1] & route_sel[hpmbx_pkg::RT_FRAME1]}))
    else $error("frame marker bits wrong");
  a_busreset_bits: assert property (
    ##1 {host_status_word[hpmbx_pkg::ST_BUSRESET2], host_status_word[hpmbx_pkg::ST_BUSRESET1]}
    == $past({engine_irq[hpmbx_pkg::EV_BUSRESET2] & route_sel[hpmbx_pkg::RT_BUSRESET2],
              engine_irq[hpmbx_pkg::EV_BUSRESET1] & route_sel[hpmbx_pkg::RT_BUSRESET1]}))
    else $error("bus reset bits wrong");
  a_wakeup_bits: assert property (
    ##1 {host_status_word[hpmbx_pkg::ST_WAKEUP2], host_status_word[hpmbx_pkg::ST_WAKEUP1]}
    == $past({engine_irq[hpmbx_pkg::EV_WAKEUP2] & route_sel[hpmbx_pkg::RT_WAKEUP2],
              engine_irq[hpmbx_pkg::EV_WAKEUP1] & route_sel[hpmbx_pkg::RT_WAKEUP1]}))
    else $error("wakeup bits wrong");
  a_complete_bits: assert property (
    ##1 {host_status_word[hpmbx_pkg::ST_COMPLETE2], host_status_word[hpmbx_pkg::ST_COMPLETE1]}
    == $past({engine_irq[hpmbx_pkg::EV_COMPLETE2] & route_sel[hpmbx_pkg::RT_COMPLETE2],
              engine_irq[hpmbx_pkg::EV_COMPLETE1] & route_sel[hpmbx_pkg::RT_COMPLETE1]}))
    else $error("completion bits wrong");

  // Sticky flags as the host sees them, two edges after their strobes.
  a_in_flag_set: assert property (
    host_mbx_wr |-> ##2 host_status_word[hpmbx_pkg::ST_MBX_IN])
    else $error("incoming flag missing");
  a_in_flag_clr: assert property (
    cpu_mbx_rd && !host_mbx_wr |-> ##2 !host_status_word[hpmbx_pkg::ST_MBX_IN])
    else $error("incoming flag stuck");
  a_msg_flag_clr: assert property (
    host_status_rd && !eng1_msg_wr |-> ##2 !host_status_word[hpmbx_pkg::ST_ENG1_MSG])
    else $error("engine message flag not cleared");
  a_out_flag_set: assert property (
    cpu_mbx_wr |-> ##2 host_status_word[hpmbx_pkg::ST_MBX_OUT])
    else $error("outgoing flag missing");
  a_out_flag_clr: assert property (
    host_mbx_rd && !cpu_mbx_wr |-> ##2 !host_status_word[hpmbx_pkg::ST_MBX_OUT])
    else $error("outgoing flag stuck");
  a_msg_flag_set: assert property (
    eng1_msg_wr |-> ##2 (host_status_word[hpmbx_pkg::ST_ENG1_MSG] && host_irq_out))
    else $error("engine message flag missing");
  a_msg2_flag_set: assert property (
    eng2_msg_wr |-> ##2 (host_status_word[hpmbx_pkg::ST_ENG2_MSG] && host_irq_out))
    else $error("second engine message flag missing");

  // Routing keeps host events away from the CPU, and a set beats a clear.
  a_route_split: assert property (
    ##1 (cpu_engine_irq & $past(routed)) == '0)
    else $error("routed event reached CPU");
  a_set_wins: assert property (
    cpu_mbx_wr && host_mbx_rd |-> ##2 host_status_word[hpmbx_pkg::ST_MBX_OUT])
    else $error("set lost to clear");

  // Main scenarios that the bench is expected to reach.
  c_host_to_cpu: cover property (host_mbx_wr ##[1:8] cpu_mbx_rd);
  c_cpu_to_host: cover property (cpu_mbx_wr ##[1:8] host_mbx_rd);
  c_routed_evt: cover property ((|ev_host) ##1 host_irq_out);
  c_collision: cover property (cpu_mbx_wr && host_mbx_wr);
  c_status_poll: cover property (host_status_rd && host_status_word[hpmbx_pkg::ST_ENG1_MSG]);
endmodule
`default_nettype wire

//--- pkg/hpmbx_pkg.sv
// Constants shared by the host port mailbox and status block.
`default_nettype none
package hpmbx_pkg;
  // Data width of the mailbox and of the status word.
  localparam int unsigned DATA_W = 16;
  // On-chip CPU addresses of the mailbox and the two engine message registers.
  localparam logic [15:0] MBX_ADDR      = 16'hc0c6;
  localparam logic [15:0] ENG1_MSG_ADDR = 16'h0144;
  localparam logic [15:0] ENG2_MSG_ADDR = 16'h0148;
  // Reset value of the mailbox.
  localparam logic [15:0] MBX_RESET     = 16'h0000;
  // Field positions in the host-side status word.
  localparam int unsigned ST_BUS_POWER  = 15;
  localparam int unsigned ST_OTG_ID     = 14;
  localparam int unsigned ST_FRAME2     = 12;
  localparam int unsigned ST_FRAME1     = 10;
  localparam int unsigned ST_BUSRESET2  = 9;
  localparam int unsigned ST_MBX_IN     = 8;
  localparam int unsigned ST_WAKEUP2    = 7;
  localparam int unsigned ST_WAKEUP1    = 6;
  localparam int unsigned ST_ENG2_MSG   = 5;
  localparam int unsigned ST_ENG1_MSG   = 4;
  localparam int unsigned ST_COMPLETE2  = 3;
  localparam int unsigned ST_COMPLETE1  = 2;
  localparam int unsigned ST_BUSRESET1  = 1;
  localparam int unsigned ST_MBX_OUT    = 0;
  // Field positions in the interrupt routing word (a 1 sends the event to the host port).
  localparam int unsigned RT_BUS_POWER  = 15;
  localparam int unsigned RT_OTG_ID     = 14;
  localparam int unsigned RT_FRAME2     = 13;
  localparam int unsigned RT_FRAME1     = 11;
  localparam int unsigned RT_BUSRESET2  = 9;
  localparam int unsigned RT_WAKEUP2    = 7;
  localparam int unsigned RT_WAKEUP1    = 6;
  localparam int unsigned RT_COMPLETE2  = 3;
  localparam int unsigned RT_COMPLETE1  = 2;
  localparam int unsigned RT_BUSRESET1  = 1;
  // Engine event vector layout, also the order of the CPU-side event outputs.
  localparam int unsigned EV_N          = 10;
  localparam int unsigned EV_BUS_POWER  = 9;
  localparam int unsigned EV_OTG_ID     = 8;
  localparam int unsigned EV_FRAME2     = 7;
  localparam int unsigned EV_FRAME1     = 6;
  localparam int unsigned EV_BUSRESET2  = 5;
  localparam int unsigned EV_WAKEUP2    = 4;
  localparam int unsigned EV_WAKEUP1    = 3;
  localparam int unsigned EV_COMPLETE2  = 2;
  localparam int unsigned EV_COMPLETE1  = 1;
  localparam int unsigned EV_BUSRESET1  = 0;
  // Sticky flag vector layout inside the block.
  localparam int unsigned FL_N          = 6;
  localparam int unsigned FL_MBX_IN     = 5;
  localparam int unsigned FL_MBX_OUT    = 4;
  localparam int unsigned FL_RX_FULL    = 3;
  localparam int unsigned FL_TX_EMPTY   = 2;
  localparam int unsigned FL_ENG2_MSG   = 1;
  localparam int unsigned FL_ENG1_MSG   = 0;
  // Bus power settling time for software, in nanoseconds, and its count of 40 ns cycles.
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned BUS_POWER_WAIT_NS = 10000;
  localparam int unsigned BUS_POWER_WAIT_CYC =
    (BUS_POWER_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

//--- rtl/hpmbx_flags.sv
// Bank of sticky flags in which a set always wins over a clear.
`timescale 1ns/1ps
`default_nettype none
module hpmbx_flags #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             core_clk,  // System clock.
  input  wire logic             sys_rst,   // Synchronous reset, active high.
  input  wire logic [WIDTH-1:0] set_i,     // Set pulses, one per flag.
  input  wire logic [WIDTH-1:0] clr_i,     // Clear pulses, one per flag.
  output logic      [WIDTH-1:0] flag_o     // Flag levels, straight from flip-flops.
);
  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] flag_next;

  // Each flag repeats the same set-dominant cell.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_flag
      assign flag_next[i] = set_i[i] | (flag_reg[i] & ~clr_i[i]);
    end
  endgenerate

  // Flags clear on reset and otherwise follow their next value.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      flag_reg <= '0;
    else
      flag_reg <= flag_next;
  end

  assign flag_o = flag_reg;
endmodule
`default_nettype wire

//--- tb/hpmbx_host_model.sv
// Behavioural model of the external host processor on the host port.
`timescale 1ns/1ps
`default_nettype none
module hpmbx_host_model (
  input  wire logic        core_clk,         // System clock.
  output logic             host_mbx_wr,      // Mailbox write strobe.
  output logic             host_mbx_rd,      // Mailbox read strobe.
  output logic             host_status_rd,   // Status word read strobe.
  output logic      [15:0] host_wdata,       // Host write data.
  input  wire logic [15:0] host_mbx_rdata,   // Mailbox word.
  input  wire logic [15:0] host_status_word  // Status word.
);
  // The bus starts idle with no strobe raised.
  initial
  begin
    host_mbx_wr = 1'b0;
    host_mbx_rd = 1'b0;
    host_status_rd = 1'b0;
    host_wdata = 16'h0000;
  end

  // One access after gap idle cycles: kind 0 writes, 1 reads the mailbox, 2 reads status.
  task automatic access(input int kind, input int gap, input logic [15:0] wd,
                        output logic [15:0] rd);
    repeat (gap) @(negedge core_clk);
    @(negedge core_clk);
    host_mbx_wr = (kind == 0);
    host_mbx_rd = (kind == 1);
    host_status_rd = (kind == 2);
    host_wdata = wd;
    @(posedge core_clk);
    rd = (kind == 2) ? host_status_word : host_mbx_rdata;
    @(negedge core_clk);
    host_mbx_wr = 1'b0;
    host_mbx_rd = 1'b0;
    host_status_rd = 1'b0;
    // Released data lines must not keep showing the last word.
    host_wdata = ~wd;
  endtask

  // Settling wait after bus power is switched on, before bit 15 is trusted.
  task automatic power_settle();
    repeat (hpmbx_pkg::BUS_POWER_WAIT_CYC) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

//--- tb/test_host_port_mailbox_status.sv
// Self-checking testbench of the host port mailbox and status block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module test_host_port_mailbox_status;
  logic        core_clk, sys_rst, cpu_wr, cpu_rd, rx_en, tx_en, bus_pwr, otg_id;
  logic        host_mbx_wr, host_mbx_rd, host_status_rd, mem_cyc, host_irq, rx_irq, tx_irq;
  logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, route_sel, mbx_rd, st_word, host_wdata, rd_w;
  logic [9:0]  engine_irq, cpu_ev;
  int          err_count = 0;
  int          check_count = 0;

  hpmbx_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .rx_full_irq_en(rx_en), .tx_empty_irq_en(tx_en), .cpu_receive_full_irq(rx_irq),
    .cpu_transmit_empty_irq(tx_irq), .host_mbx_wr(host_mbx_wr), .host_mbx_rd(host_mbx_rd),
    .host_status_rd(host_status_rd), .host_wdata(host_wdata), .host_mbx_rdata(mbx_rd),
    .host_status_word(st_word), .host_mem_cycle(mem_cyc), .host_irq_out(host_irq),
    .route_sel(route_sel), .engine_irq(engine_irq), .bus_power_above(bus_pwr),
    .otg_id_pin(otg_id), .cpu_engine_irq(cpu_ev));

  hpmbx_host_model u_host (.core_clk(core_clk), .host_mbx_wr(host_mbx_wr),
    .host_mbx_rd(host_mbx_rd), .host_status_rd(host_status_rd), .host_wdata(host_wdata),
    .host_mbx_rdata(mbx_rd), .host_status_word(st_word));

  // Clock of 40 ns period.
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // One CPU access; read data is valid when the task returns.
  task automatic cpu(input logic wr, input logic [15:0] addr, input logic [15:0] data);
    @(negedge core_clk);
    cpu_wr = wr;
    cpu_rd = ~wr;
    cpu_addr = addr;
    cpu_wdata = data;
    @(negedge core_clk);
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_reset();
    `CHK("mailbox", 16'h0000, mbx_rd)
    `CHK("host irq", 1'b0, host_irq)
    `CHK("status", 16'h0000, st_word)
    $display("test reset done");
  endtask

  task automatic t_cpu_to_host();
    cpu(1'b1, 16'hc0c6, 16'ha5c3);
    cyc(2);
    `CHK("mailbox", 16'ha5c3, mbx_rd)
    `CHK("out flag", 1'b1, st_word[0])
    `CHK("host irq", 1'b1, host_irq)
    u_host.access(1, 0, 16'h0000, rd_w);
    `CHK("host read", 16'ha5c3, rd_w)
    `CHK("mem cycle", 1'b1, mem_cyc)
    cyc(2);
    `CHK("out flag", 1'b0, st_word[0])
    `CHK("host irq", 1'b0, host_irq)
    `CHK("tx empty", 1'b1, tx_irq)
    cpu(1'b1, 16'hc0c6, 16'h5a3c);
    cyc(2);
    `CHK("tx empty", 1'b0, tx_irq)
    u_host.access(1, 1, 16'h0000, rd_w);
    `CHK("host read", 16'h5a3c, rd_w)
    $display("test cpu to host done");
  endtask

  task automatic t_host_to_cpu();
    rx_en = 1'b0;
    u_host.access(0, 2, 16'h3cc3, rd_w);
    cyc(2);
    `CHK("in flag", 1'b1, st_word[8])
    `CHK("rx full", 1'b0, rx_irq)
    rx_en = 1'b1;
    cyc(2);
    `CHK("rx full", 1'b1, rx_irq)
    cpu(1'b0, 16'hc0c6, 16'h0000);
    `CHK("cpu read", 16'h3cc3, cpu_rdata)
    cyc(2);
    `CHK("rx full", 1'b0, rx_irq)
    `CHK("in flag", 1'b0, st_word[8])
    $display("test host to cpu done");
  endtask

  task automatic t_msg();
    cpu(1'b1, 16'h0144, 16'hffff);
    cpu(1'b1, 16'h0148, 16'h0000);
    cyc(2);
    `CHK("msg flags", 2'b11, st_word[5:4])
    `CHK("host irq", 1'b1, host_irq)
    cpu(1'b0, 16'h1234, 16'h0000);
    `CHK("unmapped", 16'h0000, cpu_rdata)
    u_host.access(2, 0, 16'h0000, rd_w);
    `CHK("mem cycle", 1'b0, mem_cyc)
    `CHK("status read", 2'b11, rd_w[5:4])
    cyc(2);
    `CHK("msg flags", 2'b00, st_word[5:4])
    `CHK("host irq", 1'b0, host_irq)
    $display("test message flags done");
  endtask

  task automatic t_route();
    int          stb[10] = '{1, 2, 3, 6, 7, 9, 10, 12, 14, 15};
    int          rtb[10] = '{1, 2, 3, 6, 7, 9, 11, 13, 14, 15};
    logic [15:0] exp_st;
    for (int i = 0; i < 10; i++)
    begin
      engine_irq = 10'h001 << i;
      route_sel = 16'h0000;
      cyc(2);
      `CHK("cpu event", 10'h001 << i, cpu_ev)
      `CHK("host irq", 1'b0, host_irq)
      route_sel = 16'h0001 << rtb[i];
      cyc(2);
      exp_st = (i < 8) ? (16'h0001 << stb[i]) : 16'h0000;
      `CHK("cpu event", 10'h000, cpu_ev)
      `CHK("host irq", 1'b1, host_irq)
      `CHK("status", exp_st, st_word)
    end
    engine_irq = 10'h000;
    route_sel = 16'h0000;
    bus_pwr = 1'b1;
    otg_id = 1'b1;
    u_host.power_settle();
    u_host.access(2, 0, 16'h0000, rd_w);
    `CHK("power id", 2'b11, rd_w[15:14])
    bus_pwr = 1'b0;
    cyc(2);
    `CHK("power id", 2'b01, st_word[15:14])
    $display("test routing done");
  endtask

  task automatic t_collide();
    fork
      u_host.access(0, 0, 16'h1111, rd_w);
      cpu(1'b1, 16'hc0c6, 16'h2222);
    join
    cyc(2);
    `CHK("mailbox", 16'h2222, mbx_rd)
    `CHK("both flags", 2'b11, {st_word[8], st_word[0]})
    tx_en = 1'b0;
    fork
      u_host.access(1, 0, 16'h0000, rd_w);
      cpu(1'b1, 16'hc0c6, 16'h4444);
    join
    `CHK("host read", 16'h2222, rd_w)
    cyc(2);
    `CHK("mailbox", 16'h4444, mbx_rd)
    `CHK("out flag", 1'b1, st_word[0])
    `CHK("tx empty", 1'b0, tx_irq)
    tx_en = 1'b1;
    cyc(2);
    `CHK("tx empty", 1'b1, tx_irq)
    $display("test collision done");
  endtask

  // Main sequence: reset for 10 cycles, then every test in turn.
  initial
  begin
    sys_rst = 1'b1;
    {cpu_wr, cpu_rd, bus_pwr, otg_id} = 4'h0;
    {rx_en, tx_en} = 2'b11;
    cpu_addr = 16'h0000;
    cpu_wdata = 16'h0000;
    route_sel = 16'h0000;
    engine_irq = 10'h000;
    cyc(10);
    sys_rst = 1'b0;
    t_reset();
    t_cpu_to_host();
    t_host_to_cpu();
    t_msg();
    t_route();
    t_collide();
    end_sim();
  end

  // Watchdog well beyond the expected run of under a thousand cycles.
  initial
  begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
